// *** dcb_pkg.sv ***
// Constants for the 10-bit converter code double buffer block.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package dcb_pkg;

   localparam int DCB_ADDR_W = 8;
   localparam int DCB_CODE_W = 10;
   localparam int DCB_INST = 2;

   // Byte offsets of the register words
   localparam logic [7:0] DCB_OFS_CTRL0 = 8'h00;
   localparam logic [7:0] DCB_OFS_HIGH0 = 8'h04;
   localparam logic [7:0] DCB_OFS_LOW0 = 8'h08;
   localparam logic [7:0] DCB_OFS_CTRL1 = 8'h0c;
   localparam logic [7:0] DCB_OFS_HIGH1 = 8'h10;
   localparam logic [7:0] DCB_OFS_LOW1 = 8'h14;
   localparam logic [7:0] DCB_OFS_LOAD = 8'h18;
   localparam logic [7:0] DCB_OFS_CODE0 = 8'h1c;
   localparam logic [7:0] DCB_OFS_CODE1 = 8'h20;

   // Control register fields
   localparam int DCB_CTRL_EN = 7;
   localparam int DCB_CTRL_JUSTIFY = 6;
   localparam int DCB_CTRL_PIN_OE = 5;
   localparam int DCB_CTRL_TOP_HI = 3;
   localparam int DCB_CTRL_TOP_LO = 2;
   localparam int DCB_CTRL_BOTTOM = 0;
   localparam logic [7:0] DCB_CTRL_MASK = 8'hed;
   localparam logic [7:0] DCB_CTRL_RESET = 8'h00;
   localparam logic [9:0] DCB_CODE_RESET = 10'h000;
   localparam logic [1:0] DCB_LOAD_RESET = 2'h0;

   typedef enum logic [1:0] {
      DCB_TOP_SUPPLY = 2'h0,
      DCB_TOP_EXT_PIN = 2'h1,
      DCB_TOP_FIXED_REF2 = 2'h2,
      DCB_TOP_RESERVED = 2'h3
   } dcb_top_src_e;

   localparam logic [1:0] DCB_RESP_OKAY = 2'h0;
   localparam logic [1:0] DCB_RESP_SLVERR = 2'h2;

endpackage : dcb_pkg

// *** dcb_reg_if.sv ***
// Internal register access path between the bus slave and the core.
// Assumes one write and one read at most per cycle.
`timescale 1ns/100ps
interface dcb_reg_if;
   import dcb_pkg::*;
   logic wr_en;
   logic wr_lane0;
   logic [DCB_ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_err;
   logic [DCB_ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_err;
   modport bus (output wr_en, wr_lane0, wr_addr, wr_data, rd_addr,
      input wr_err, rd_data, rd_err);
   modport core (input wr_en, wr_lane0, wr_addr, wr_data, rd_addr,
      output wr_err, rd_data, rd_err);
endinterface : dcb_reg_if

// *** dcb_axil_slave.sv ***
// AXI4-Lite slave that turns bus transfers into register accesses.
// Assumes the core decodes addresses combinationally.
`timescale 1ns/100ps
module dcb_axil_slave (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Write channels
   input wire logic [dcb_pkg::DCB_ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // Read channels
   input wire logic [dcb_pkg::DCB_ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Core side
   dcb_reg_if.bus reg_bus
);
   import dcb_pkg::*;

   logic aw_held_reg;
   logic w_held_reg;
   logic [DCB_ADDR_W-1:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wlane_reg;
   logic do_write;

   assign do_write = aw_held_reg && w_held_reg && !o_bvalid;
   assign reg_bus.wr_en = do_write;
   assign reg_bus.wr_lane0 = wlane_reg;
   assign reg_bus.wr_addr = awaddr_reg;
   assign reg_bus.wr_data = wdata_reg;
   assign reg_bus.rd_addr = i_araddr;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_held_reg <= 1'b0;
         o_awready <= 1'b0;
         awaddr_reg <= '0;
      end else if (i_awvalid && o_awready) begin
         aw_held_reg <= 1'b1;
         o_awready <= 1'b0;
         awaddr_reg <= i_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !o_bvalid) begin
         o_awready <= 1'b1;
      end
   end

   // Only the low byte lane carries register bits
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_held_reg <= 1'b0;
         o_wready <= 1'b0;
         wdata_reg <= 8'h00;
         wlane_reg <= 1'b0;
      end else if (i_wvalid && o_wready) begin
         w_held_reg <= 1'b1;
         o_wready <= 1'b0;
         wdata_reg <= i_wdata[7:0];
         wlane_reg <= i_wstrb[0];
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end else if (!w_held_reg && !o_bvalid) begin
         o_wready <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bvalid <= 1'b0;
         o_bresp <= DCB_RESP_OKAY;
      end else if (do_write) begin
         o_bvalid <= 1'b1;
         o_bresp <= reg_bus.wr_err ? DCB_RESP_SLVERR : DCB_RESP_OKAY;
      end else if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= DCB_RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= {24'h00_0000, reg_bus.rd_data};
         o_rresp <= reg_bus.rd_err ? DCB_RESP_SLVERR : DCB_RESP_OKAY;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end else if (!o_rvalid) begin
         o_arready <= 1'b1;
      end
   end

endmodule : dcb_axil_slave

// *** dcb_channel.sv ***
// One converter instance: control word, holding code and double buffer.
// Assumes write strobes and the load pulse are one cycle each.
`timescale 1ns/100ps
module dcb_channel (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register writes
   input wire logic i_ctrl_we,
   input wire logic i_high_we,
   input wire logic i_low_we,
   input wire logic [7:0] i_wdata,
   input wire logic i_load,
   // Register reads and ladder drive
   output logic [7:0] o_ctrl,
   output logic [7:0] o_high_rd,
   output logic [7:0] o_low_rd,
   output logic [dcb_pkg::DCB_CODE_W-1:0] o_code
);
   import dcb_pkg::*;

   logic [DCB_CODE_W-1:0] hold_reg;
   logic [DCB_CODE_W-1:0] hold_next;
   logic left;

   function automatic logic [7:0] high_view(input logic lj,
      input logic [9:0] c);
      high_view = lj ? c[9:2] : {6'h00, c[9:8]}; // [RQ1] [RQ2] [RQ3]
   endfunction : high_view

   function automatic logic [7:0] low_view(input logic lj,
      input logic [9:0] c);
      low_view = lj ? {c[1:0], 6'h00} : c[7:0]; // [RQ1] [RQ2] [RQ3]
   endfunction : low_view

   assign left = o_ctrl[DCB_CTRL_JUSTIFY];
   assign o_high_rd = high_view(left, hold_reg);
   assign o_low_rd = low_view(left, hold_reg);

   // Sleep wake-up has no path here; only reset and bus writes act
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ctrl <= DCB_CTRL_RESET; // [RQ9] [RQ11]
      end else if (i_ctrl_we) begin
         o_ctrl <= i_wdata & DCB_CTRL_MASK; // [RQ10] [RQ11]
      end
   end

   always_comb begin
      hold_next = hold_reg;
      if (i_high_we && left) begin
         hold_next[9:2] = i_wdata; // [RQ1]
      end else if (i_high_we) begin
         hold_next[9:8] = i_wdata[1:0]; // [RQ2]
      end
      if (i_low_we && left) begin
         hold_next[1:0] = i_wdata[7:6]; // [RQ1]
      end else if (i_low_we) begin
         hold_next[7:0] = i_wdata; // [RQ2]
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_reg <= DCB_CODE_RESET; // [RQ9]
      end else begin
         hold_reg <= hold_next;
      end
   end

   // Ladder code never follows the holding register directly
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_code <= DCB_CODE_RESET; // [RQ9]
      end else if (i_load) begin
         o_code <= hold_reg; // [RQ5] [RQ18]
      end
   end

   a_load_copies: assert property ( // [RQ5]
      @(posedge i_clk) disable iff (!i_rst_n)
      i_load |=> o_code == $past(hold_reg))
      else $error("buffer did not take the holding code");
   a_code_holds: assert property ( // [RQ4]
      @(posedge i_clk) disable iff (!i_rst_n)
      !i_load |=> $stable(o_code))
      else $error("ladder code changed without a load");
   a_pad_zero: assert property ( // [RQ3]
      @(posedge i_clk) disable iff (!i_rst_n)
      left ? (o_low_rd[5:0] == 6'h00) : (o_high_rd[7:2] == 6'h00))
      else $error("unused code register bits not zero");
   a_left_view: assert property ( // [RQ1]
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_high_we && left) |=> (o_high_rd == $past(i_wdata)) || !left)
      else $error("left justified high write not visible");
   c_load_seen: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      i_load ##1 $changed(o_code));

endmodule : dcb_channel

// *** dcb_top.sv ***
// Notes on behaviour
// (RQ1) Left justified: high register holds code 9..2, low bits 7..6 code 1..0.
// (RQ2) Right justified: low register holds code 7..0, high bits 1..0 code 9..8.
// (RQ3) Code register positions without code bits read as zero.
// (RQ4) Writing holding registers never changes the code in use.
// (RQ5) Writing 1 to a load bit copies both holding halves at once.
// (RQ6) The load bit clears itself after the transfer.
// (RQ7) Writing 0 to a load bit leaves the buffer unchanged.
// (RQ8) Load register: bit 0 first instance, bit 1 second, rest zero.
// (RQ9) Reset disables, disconnects the pin and clears all ten code bits.
// (RQ10) Waking from sleep leaves the control register unchanged.
// (RQ11) Control: enable 7, justify 6, pin 5, top 3..2, bottom 0.
// (RQ12) Top source 00 supply, 01 external pin, 10 fixed reference buffer.
// (RQ13) Bottom source 1 external negative pin, 0 ground.
// (RQ14) Pin output enable routes the converter level to the pin.
// (RQ15) The converter runs only while its enable bit is set.
// (RQ16) Level is bottom plus span times buffered code over 1024.
// (RQ17) While the pin carries the level, its digital read returns zero; here the registered read is zero from the cycle after.
// (RQ18) The ladder code always comes from the double buffer.
//
// Top of the two-instance converter code double buffer block.
// Assumes an AXI4-Lite master on I_MCLK and an analog ladder outside.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module dcb_top (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_NRST,
   // AXI4-Lite write address and data
   input wire logic [dcb_pkg::DCB_ADDR_W-1:0] I_AWADDR,
   input wire logic [2:0] I_AWPROT,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   // AXI4-Lite write response
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // AXI4-Lite read
   input wire logic [dcb_pkg::DCB_ADDR_W-1:0] I_ARADDR,
   input wire logic [2:0] I_ARPROT,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // Analog ladder control, one entry per instance
   output logic [1:0][9:0] O_LADDER_CODE,
   output logic [1:0] O_CONV_ENABLE,
   output logic [1:0][1:0] O_TOP_SOURCE,
   output logic [1:0] O_BOTTOM_SOURCE,
   // Output pin switch and digital override
   output logic [1:0] O_PIN_LEVEL_CONNECT,
   input wire logic [1:0] I_PIN_DIGITAL,
   output logic [1:0] O_PIN_DIGITAL_READ
);
   import dcb_pkg::*;

   dcb_reg_if reg_path ();

   logic [1:0] ctrl_we;
   logic [1:0] high_we;
   logic [1:0] low_we;
   logic load_we;
   logic [1:0] load_set;
   logic [1:0] load_pend_reg;
   logic [1:0][7:0] ctrl_q;
   logic [1:0][7:0] high_rd;
   logic [1:0][7:0] low_rd;
   logic [1:0][9:0] code_q;
   logic [1:0] pin_s1_reg;
   logic [1:0] pin_s2_reg;
   logic [1:0] pin_s3_reg;
   logic [1:0] pin_level_reg;
   logic [7:0] rd_mux;
   logic rd_miss;

   function automatic logic [7:0] word_of(input logic [7:0] a);
      word_of = {a[7:2], 2'h0};
   endfunction : word_of

   function automatic logic is_mapped(input logic [7:0] a);
      case (word_of(a))
         DCB_OFS_CTRL0, DCB_OFS_HIGH0, DCB_OFS_LOW0,
         DCB_OFS_CTRL1, DCB_OFS_HIGH1, DCB_OFS_LOW1,
         DCB_OFS_LOAD, DCB_OFS_CODE0, DCB_OFS_CODE1: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   function automatic logic hit(input logic [7:0] a,
      input logic [7:0] ofs);
      hit = (word_of(a) == ofs);
   endfunction : hit

   dcb_axil_slave u_slave (
      .i_clk(I_MCLK),
      .i_rst_n(I_NRST),
      .i_awaddr(I_AWADDR),
      .i_awvalid(I_AWVALID),
      .o_awready(O_AWREADY),
      .i_wdata(I_WDATA),
      .i_wstrb(I_WSTRB),
      .i_wvalid(I_WVALID),
      .o_wready(O_WREADY),
      .o_bresp(O_BRESP),
      .o_bvalid(O_BVALID),
      .i_bready(I_BREADY),
      .i_araddr(I_ARADDR),
      .i_arvalid(I_ARVALID),
      .o_arready(O_ARREADY),
      .o_rdata(O_RDATA),
      .o_rresp(O_RRESP),
      .o_rvalid(O_RVALID),
      .i_rready(I_RREADY),
      .reg_bus(reg_path.bus)
   );

   // Write decode; the code status words are read only
   logic wr_go;
   assign wr_go = reg_path.wr_en && reg_path.wr_lane0;
   assign ctrl_we[0] = wr_go && hit(reg_path.wr_addr, DCB_OFS_CTRL0);
   assign ctrl_we[1] = wr_go && hit(reg_path.wr_addr, DCB_OFS_CTRL1);
   assign high_we[0] = wr_go && hit(reg_path.wr_addr, DCB_OFS_HIGH0);
   assign high_we[1] = wr_go && hit(reg_path.wr_addr, DCB_OFS_HIGH1);
   assign low_we[0] = wr_go && hit(reg_path.wr_addr, DCB_OFS_LOW0);
   assign low_we[1] = wr_go && hit(reg_path.wr_addr, DCB_OFS_LOW1);
   assign load_we = wr_go && hit(reg_path.wr_addr, DCB_OFS_LOAD);
   assign load_set = load_we ? reg_path.wr_data[1:0] : 2'h0; // [RQ7] [RQ8]
   assign reg_path.wr_err = !is_mapped(reg_path.wr_addr);

   // A pending bit lives one cycle; a new 1 written then wins the clear
   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         load_pend_reg <= DCB_LOAD_RESET;
      end else begin
         load_pend_reg <= load_set; // [RQ5] [RQ6]
      end
   end

   genvar g;
   generate
      for (g = 0; g < DCB_INST; g++) begin : g_inst
         dcb_channel u_chan (
            .i_clk(I_MCLK),
            .i_rst_n(I_NRST),
            .i_ctrl_we(ctrl_we[g]),
            .i_high_we(high_we[g]),
            .i_low_we(low_we[g]),
            .i_wdata(reg_path.wr_data),
            .i_load(load_pend_reg[g]), // [RQ5]
            .o_ctrl(ctrl_q[g]),
            .o_high_rd(high_rd[g]),
            .o_low_rd(low_rd[g]),
            .o_code(code_q[g])
         );
      end
   endgenerate

   // Read decode
   always_comb begin
      rd_mux = 8'h00;
      rd_miss = 1'b0;
      case (word_of(reg_path.rd_addr))
         DCB_OFS_CTRL0: rd_mux = ctrl_q[0];
         DCB_OFS_HIGH0: rd_mux = high_rd[0]; // [RQ3]
         DCB_OFS_LOW0: rd_mux = low_rd[0]; // [RQ3]
         DCB_OFS_CTRL1: rd_mux = ctrl_q[1];
         DCB_OFS_HIGH1: rd_mux = high_rd[1];
         DCB_OFS_LOW1: rd_mux = low_rd[1];
         DCB_OFS_LOAD: rd_mux = {6'h00, load_pend_reg}; // [RQ8]
         DCB_OFS_CODE0: rd_mux = code_q[0][9:2];
         DCB_OFS_CODE1: rd_mux = code_q[1][9:2];
         default: rd_miss = 1'b1;
      endcase
   end
   assign reg_path.rd_data = rd_mux;
   assign reg_path.rd_err = rd_miss;

   // Analog drive straight from the buffer and control flip-flops.
   // The ladder forms bottom + (top - bottom) * code / 1024 itself.
   always_comb begin
      for (int i = 0; i < DCB_INST; i++) begin
         O_LADDER_CODE[i] = code_q[i]; // [RQ16] [RQ18]
         O_CONV_ENABLE[i] = ctrl_q[i][DCB_CTRL_EN]; // [RQ15] [RQ9]
         O_TOP_SOURCE[i] =
            ctrl_q[i][DCB_CTRL_TOP_HI:DCB_CTRL_TOP_LO]; // [RQ12]
         O_BOTTOM_SOURCE[i] = ctrl_q[i][DCB_CTRL_BOTTOM]; // [RQ13]
         O_PIN_LEVEL_CONNECT[i] = ctrl_q[i][DCB_CTRL_PIN_OE]; // [RQ14]
      end
   end

   // Pin input crossing; stage one feeds stage two only
   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pin_s1_reg <= 2'h0;
         pin_s2_reg <= 2'h0;
         pin_s3_reg <= 2'h0;
      end else begin
         pin_s1_reg <= I_PIN_DIGITAL;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pin_level_reg <= 2'h0;
      end else begin
         for (int i = 0; i < DCB_INST; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_level_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   // Digital read is registered low from the cycle after the pin starts carrying the level
   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_PIN_DIGITAL_READ <= 2'h0;
      end else begin
         for (int i = 0; i < DCB_INST; i++) begin
            O_PIN_DIGITAL_READ[i] <= ctrl_q[i][DCB_CTRL_PIN_OE] ? 1'b0 :
               pin_level_reg[i]; // [RQ17]
         end
      end
   end

   // Checks on load pulses, read padding, pin routing, control fields and the write response
   a_load_clears: assert property ( // [RQ6]
      @(posedge I_MCLK) disable iff (!I_NRST)
      (load_pend_reg[0] && !load_set[0]) |=> !load_pend_reg[0])
      else $error("load bit did not clear itself");

   a_load_clears_b: assert property ( // [RQ6]
      @(posedge I_MCLK) disable iff (!I_NRST)
      (load_pend_reg[1] && !load_set[1]) |=> !load_pend_reg[1])
      else $error("second load bit did not clear itself");

   a_load_zero_keeps: assert property ( // [RQ7]
      @(posedge I_MCLK) disable iff (!I_NRST)
      (load_we && !reg_path.wr_data[1]) |=> ##1 $stable(O_LADDER_CODE[1]))
      else $error("zero load changed the buffer");

   a_load_zero_keeps_a: assert property ( // [RQ7]
      @(posedge I_MCLK) disable iff (!I_NRST)
      (load_we && !reg_path.wr_data[0]) |=> ##1 $stable(O_LADDER_CODE[0]))
      else $error("zero load changed the first buffer");

   a_load_reads: assert property ( // [RQ8]
      @(posedge I_MCLK) disable iff (!I_NRST)
      (I_ARVALID && O_ARREADY) |=> O_RDATA[31:8] == 24'h00_0000)
      else $error("unimplemented read bits not zero");

   a_load_bits_read: assert property ( // [RQ8]
      @(posedge I_MCLK) disable iff (!I_NRST)
      (I_ARVALID && O_ARREADY && hit(I_ARADDR, DCB_OFS_LOAD))
      |=> O_RDATA[7:2] == 6'h00)
      else $error("load register upper bits not zero");

   a_pin_read_low: assert property ( // [RQ17]
      @(posedge I_MCLK) disable iff (!I_NRST)
      O_PIN_LEVEL_CONNECT[0] |=> !O_PIN_DIGITAL_READ[0])
      else $error("pin digital read not forced low");

   a_pin_read_low_b: assert property ( // [RQ17]
      @(posedge I_MCLK) disable iff (!I_NRST)
      O_PIN_LEVEL_CONNECT[1] |=> !O_PIN_DIGITAL_READ[1])
      else $error("second pin digital read not forced low");

   a_pin_follows: assert property ( // [RQ14]
      @(posedge I_MCLK) disable iff (!I_NRST)
      ctrl_we[1] |=> O_PIN_LEVEL_CONNECT[1] ==
         $past(reg_path.wr_data[DCB_CTRL_PIN_OE]))
      else $error("pin connection does not follow control write");

   a_bottom_follows: assert property ( // [RQ13]
      @(posedge I_MCLK) disable iff (!I_NRST)
      ctrl_we[0] |=> O_BOTTOM_SOURCE[0] ==
         $past(reg_path.wr_data[DCB_CTRL_BOTTOM]))
      else $error("bottom source does not follow control write");

   a_ctrl_mask: assert property ( // [RQ11]
      @(posedge I_MCLK) disable iff (!I_NRST)
      ctrl_we[0] |=> ctrl_q[0] == ($past(reg_path.wr_data) & 8'hed))
      else $error("control register field layout wrong");

   a_write_resp: assert property ( // [RQ4]
      @(posedge I_MCLK) disable iff (!I_NRST)
      reg_path.wr_en |=> O_BVALID ##0 $stable(O_LADDER_CODE)[*1])
      else $error("write response or code stability wrong");

   c_pin_on: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
      $rose(O_PIN_LEVEL_CONNECT[0]));

   c_left_mode: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
      ctrl_q[1][DCB_CTRL_JUSTIFY] && load_pend_reg[1]);

   c_both_load: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
      load_pend_reg == 2'h3);

   c_bad_addr: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
      O_BVALID && O_BRESP == DCB_RESP_SLVERR);

endmodule : dcb_top

// *** dcb_top_tb.sv ***
// Self-checking bench for the two-instance converter code double buffer.
// Assumes dcb_pkg offsets and an AXI4-Lite slave that answers in time.
`timescale 1ns/100ps
module dcb_top_tb;
   import dcb_pkg::*;
   logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, conv_en, bottom, connect, pin, pin_rd;
   logic [1:0][9:0] ladder;
   logic [1:0][1:0] top_src;
   logic [9:0] hold [2];
   logic [9:0] bufd [2];
   logic [7:0] ctl [2];
   int err_count = 0;
   int n_tests = 0;

   dcb_top i_dut (.I_MCLK(mclk), .I_NRST(rst_n), .I_AWADDR(awaddr),
      .I_AWPROT(awprot), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
      .I_BREADY(bready), .I_ARADDR(araddr), .I_ARPROT(arprot),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .O_LADDER_CODE(ladder), .O_CONV_ENABLE(conv_en),
      .O_TOP_SOURCE(top_src), .O_BOTTOM_SOURCE(bottom),
      .O_PIN_LEVEL_CONNECT(connect), .I_PIN_DIGITAL(pin),
      .O_PIN_DIGITAL_READ(pin_rd));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Readback views and write updates of a 10-bit code under either justification
   function automatic logic [7:0] f_rh(logic [9:0] c, logic fm);
      return fm ? c[9:2] : {6'h00, c[9:8]};
   endfunction : f_rh
   function automatic logic [7:0] f_rl(logic [9:0] c, logic fm);
      return fm ? {c[1:0], 6'h00} : c[7:0];
   endfunction : f_rl
   function automatic logic [9:0] f_wh(logic [9:0] c, logic [7:0] d,
         logic fm);
      return fm ? {d, c[1:0]} : {d[1:0], c[7:0]};
   endfunction : f_wh
   function automatic logic [9:0] f_wl(logic [9:0] c, logic [7:0] d,
         logic fm);
      return fm ? {c[9:2], d[7:6]} : {c[9:8], d};
   endfunction : f_wl

   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
         input logic [3:0] s, output logic [1:0] r);
      logic aw_ok, w_ok;
      int n;
      @(posedge mclk);
      awaddr <= a;
      awprot <= 3'($urandom);
      wdata <= {24'($urandom), d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      while (!(aw_ok && w_ok) && n < 64) begin
         @(posedge mclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
         n++;
      end
      do begin
         @(posedge mclk);
         n++;
      end while (bvalid !== 1'b1 && n < 128);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int n;
      @(posedge mclk);
      araddr <= a;
      arprot <= 3'($urandom);
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         n++;
      end while (rvalid !== 1'b1 && n < 64);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rd_ok(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk("rdata", 32'(e), d);
      chk("rresp", 32'(DCB_RESP_OKAY), 32'(r));
   endtask : rd_ok

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      final_report();
   end

   initial begin
      logic [7:0] c, hi, lo, ld, base;
      logic [1:0] r;
      logic [31:0] d;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      awprot = 3'h0;
      arprot = 3'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      pin = 2'h0;
      void'($urandom(32'haeb0));
      for (int i = 0; i < 2; i++) begin
         hold[i] = DCB_CODE_RESET;
         bufd[i] = DCB_CODE_RESET;
         ctl[i] = DCB_CTRL_RESET;
      end
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 0; a <= 32; a += 4) begin
         rd_ok(8'(a), 8'h00);
      end
      for (int i = 0; i < 2; i++) begin
         for (int it = 0; it < 12; it++) begin
            base = 8'(i * 12);
            pin <= 2'($urandom);
            c = 8'($urandom);
            c[3:2] = 2'(it % 3);
            c[6] = it[0];
            wr(base, c, 4'hf, r);
            ctl[i] = c & DCB_CTRL_MASK;
            rd_ok(base, ctl[i]);
            chk("enable", 32'(c[7]), 32'(conv_en[i]));
            chk("top", 32'(c[3:2]), 32'(top_src[i]));
            chk("bottom", 32'(c[0]), 32'(bottom[i]));
            chk("connect", 32'(c[5]), 32'(connect[i]));
            hi = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
            lo = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
            wr(base + 8'h04, hi, 4'hf, r);
            hold[i] = f_wh(hold[i], hi, c[6]);
            wr(base + 8'h08, lo, 4'hf, r);
            hold[i] = f_wl(hold[i], lo, c[6]);
            rd_ok(base + 8'h04, f_rh(hold[i], c[6]));
            rd_ok(base + 8'h08, f_rl(hold[i], c[6]));
            chk("ladder", 32'(bufd[i]), 32'(ladder[i]));
            // Upper junk bits must never start the other instance
            ld = {6'($urandom), 2'b00};
            ld[i] = (it % 3 != 2);
            wr(DCB_OFS_LOAD, ld, 4'hf, r);
            if (ld[i]) begin
               bufd[i] = hold[i];
            end
            rd_ok(DCB_OFS_LOAD, 8'h00);
            chk("ladder", 32'(bufd[i]), 32'(ladder[i]));
            chk("other", 32'(bufd[1-i]), 32'(ladder[1-i]));
            rd_ok(DCB_OFS_CODE0 + 8'(4 * i), bufd[i][9:2]);
            chk("pin", 32'(c[5] ? 1'b0 : pin[i]), 32'(pin_rd[i]));
         end
      end
      wr(DCB_OFS_HIGH1, 8'h5a, 4'hf, r);
      hold[1] = f_wh(hold[1], 8'h5a, ctl[1][6]);
      wr(DCB_OFS_LOAD, 8'h03, 4'hf, r);
      @(posedge mclk);
      chk("ladder0", 32'(hold[0]), 32'(ladder[0]));
      chk("ladder1", 32'(hold[1]), 32'(ladder[1]));
      wr(DCB_OFS_CTRL0, 8'hff, 4'h0, r);
      chk("bresp", 32'(DCB_RESP_OKAY), 32'(r));
      rd_ok(DCB_OFS_CTRL0, ctl[0]);
      wr(DCB_OFS_CODE0, 8'h55, 4'hf, r);
      rd_ok(DCB_OFS_CODE0, hold[0][9:2]);
      wr(8'h24, 8'h11, 4'hf, r);
      chk("bresp", 32'(DCB_RESP_SLVERR), 32'(r));
      rd(8'h3c, d, r);
      chk("rresp", 32'(DCB_RESP_SLVERR), 32'(r));
      chk("rdata", 32'h0, d);
      wr(DCB_OFS_CTRL0, 8'ha0, 4'hf, r);
      chk("connect", 32'h1, 32'(connect[0]));
      // A second reset in mid-run must clear code and disconnect the pin
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      #1;
      chk("ladder", 32'h0, 32'(ladder));
      chk("enable", 32'h0, 32'(conv_en));
      chk("connect", 32'h0, 32'(connect));
      @(posedge mclk);
      rst_n <= 1'b1;
      rd_ok(DCB_OFS_CTRL0, 8'h00);
      rd_ok(DCB_OFS_HIGH1, 8'h00);
      final_report();
   end
endmodule : dcb_top_tb
